/* File: rtl/cpw_top.sv */
/*
  Circular position wrap block: wrapping actual and encoder position,
  fractional revolution extension, revolution counter, blocking zones and
  direction choice, with an AHB-Lite register slave and an interrupt.
  Assumes step requests, encoder counts and capture strobes come from
  logic on hclk; the ramp generator honours move_dir and vstop_ramp.
*/
// Notes on behaviour
// - With circular motion, position stays in -range..range-1 and jumps across the limits.
// - Each wrap adds the fraction extension into an internal accumulator.
// - Positioning with circular motion and a stop disabled picks the shorter way, across the wrap if needed.
// - Accumulator overflow holds position at the wrap point one extra step.
// - Extension 2^31 equals one step; 0x40000000 overflows every second revolution.
// - Extension above one step adds up to two held steps in one revolution.
// - Revolution counter counts up on forward wrap, down on backward wrap.
// - By default the shared read address returns the captured position.
// - Counter select bit makes the shared address return the revolution counter.
// - Counter is forced to zero while circular motion is off.
// - With circular motion and both stops enabled, positioning avoids the blocking zone even if longer.
// - Reaching a zone limit starts the virtual stop deceleration request.
// - Left below right: blocked at or below left, or at or above right.
// - Left above right: blocked only when both conditions hold.
// - Reading the event register clears latched virtual stop events.
// - After clearing and a new target, motion restarts along the allowed way.
// - With circular motion on, the encoder circular bit wraps the encoder position the same way.
`timescale 1ns/1ps
`default_nettype none
`include "cpw_params.svh"

module cpw_top
  import cpw_pkg::*;
(
  input wire logic hclk, // System clock
  input wire logic hresetn, // Async reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size, word only
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic [31:0] hrdata, // Read data
  output logic hreadyout, // Slave ready
  output logic hresp, // Always OKAY
  input wire logic step_req, // Ramp asks for one step
  input wire logic step_req_dir, // Velocity mode direction, high forward
  input wire logic enc_step, // Encoder count pulse
  input wire logic enc_dir, // Encoder direction, high forward
  input wire logic capture_strobe, // Capture actual position
  output logic step_out, // Step issued
  output logic move_dir, // Direction in use, high forward
  output logic vstop_ramp, // Virtual stop deceleration request
  output logic [31:0] actual_position, // Actual position
  output logic irq // Interrupt level
);

  cpw_state_s s;
  cpw_state_s next_s;

  logic take;
  logic dphase_wr;
  logic dphase_rd;
  logic circ_act;
  logic zone_on;
  logic pos_mode;
  logic dir_pos;
  logic dir_use;
  logic step_ok;
  logic [3:0] ev_set;
  logic [32:0] frac_sum;
  cpw_wrap_s w;
  cpw_wrap_s we;

  // Subtraction modulo twice the range; both operands lie in -r..r-1
  function automatic logic [31:0] mod_sub(input logic [31:0] a, input logic [31:0] b,
                                          input logic [31:0] r);
    logic signed [33:0] d;
    d = {{2{a[31]}}, a} - {{2{b[31]}}, b};
    if (d < 0) begin
      d = d + {1'b0, r, 1'b0};
    end
    return d[31:0];
  endfunction

  function automatic logic is_blocked(input logic [31:0] x, input logic [31:0] l,
                                      input logic [31:0] r);
    logic below;
    logic above;
    below = $signed(x) <= $signed(l);
    above = $signed(x) >= $signed(r);
    if ($signed(l) < $signed(r)) begin
      return below || above;
    end
    return below && above;
  endfunction

  function automatic cpw_wrap_s wrap_step(input logic [31:0] p, input logic fwd,
                                          input logic circ, input logic [31:0] r);
    cpw_wrap_s o;
    o = '0;
    if (fwd) begin
      if (circ && p == r - 32'h00000001) begin
        o.pos = 32'h00000000 - r;
        o.fwd = 1'b1;
      end else begin
        o.pos = p + 32'h00000001;
      end
    end else begin
      if (circ && p == 32'h00000000 - r) begin
        o.pos = r - 32'h00000001;
        o.back = 1'b1;
      end else begin
        o.pos = p - 32'h00000001;
      end
    end
    return o;
  endfunction

  assign take = hsel && hready && htrans[1];
  assign dphase_wr = (s.bus == CPW_BUS_DATA) && s.wr;
  assign dphase_rd = (s.bus == CPW_BUS_DATA) && !s.wr;
  assign circ_act = s.refc[`CPW_REF_CIRC] && (s.range != `CPW_RST_WORD);
  assign zone_on = circ_act && s.refc[`CPW_REF_LEFT_EN] && s.refc[`CPW_REF_RIGHT_EN];
  assign pos_mode = s.ramp[`CPW_RAMP_POS];

  always_comb begin
    if (zone_on) begin
      // Compare distances from the left limit so that the free arc never wraps
      dir_pos = mod_sub(s.target, s.left, s.range) > mod_sub(s.actual, s.left, s.range);
    end else if (circ_act) begin
      dir_pos = mod_sub(s.target, s.actual, s.range) < s.range;
    end else begin
      dir_pos = $signed(s.target) > $signed(s.actual);
    end
  end

  assign dir_use = pos_mode ? dir_pos : step_req_dir;
  // Latched stop events freeze stepping until software reads them away
  assign step_ok = step_req && (s.events[1:0] == 2'h0) &&
                   (!pos_mode || (s.run && s.actual != s.target));
  assign w = wrap_step(s.actual, dir_use, circ_act, s.range);
  assign we = wrap_step(s.enc, enc_dir, circ_act && s.refc[`CPW_REF_ENC_CIRC], s.range);
  // Fraction uses 31 bits; bits 32:31 of the sum give 0..2 held steps
  assign frac_sum = {2'b00, s.acc[30:0]} + {1'b0, s.ext};

  always_comb begin
    next_s = s;
    ev_set = 4'h0;
    next_s.step_o = 1'b0;
    next_s.dir_o = dir_use;

    // Bus address and data phases; one wait state per transfer
    next_s.ready = 1'b1;
    next_s.bus = CPW_BUS_IDLE;
    if (take) begin
      next_s.bus = CPW_BUS_DATA;
      next_s.idx = haddr[9:2];
      next_s.wr = hwrite;
      next_s.ready = 1'b0;
    end

    if (dphase_rd) begin
      case (s.idx)
        `CPW_IDX_GEN_CONF: next_s.rdata = s.gen;
        `CPW_IDX_REF_CONF: next_s.rdata = s.refc;
        `CPW_IDX_EVENTS: next_s.rdata = {28'h0000000, s.events};
        `CPW_IDX_RAMP_KIND: next_s.rdata = {29'h00000000, s.ramp};
        `CPW_IDX_ACTUAL: next_s.rdata = s.actual;
        `CPW_IDX_TARGET: next_s.rdata = s.target;
        `CPW_IDX_LEFT: next_s.rdata = s.left;
        `CPW_IDX_RIGHT: next_s.rdata = s.right;
        `CPW_IDX_LATCH_REV: next_s.rdata = s.gen[`CPW_GEN_CNT_SEL] ? s.rev : s.latch;
        `CPW_IDX_ENC_POS: next_s.rdata = s.enc;
        `CPW_IDX_INT_STATUS: next_s.rdata = {28'h0000000, s.ist};
        `CPW_IDX_INT_ENABLE: next_s.rdata = {28'h0000000, s.ien};
        `CPW_IDX_EXTENSION: next_s.rdata = s.ext;
        default: next_s.rdata = `CPW_RST_WORD;
      endcase
      if (s.idx == `CPW_IDX_EVENTS) begin
        next_s.events = 4'h0;
      end
    end

    // Motion: held steps move the motor but not the position value
    if (step_ok) begin
      next_s.step_o = 1'b1;
      if (s.hold != 2'h0) begin
        next_s.hold = s.hold - 2'h1;
      end else begin
        next_s.actual = w.pos;
        if (w.fwd) begin
          next_s.rev = s.rev + 32'h00000001;
        end
        if (w.back) begin
          next_s.rev = s.rev - 32'h00000001;
        end
        if (w.fwd || w.back) begin
          next_s.acc = {1'b0, frac_sum[30:0]};
          next_s.hold = frac_sum[32:31];
          ev_set[`CPW_EV_WRAP] = 1'b1;
        end
        if (zone_on && is_blocked(w.pos, s.left, s.right) &&
            !is_blocked(s.actual, s.left, s.right)) begin
          if ($signed(w.pos) <= $signed(s.left)) begin
            ev_set[`CPW_EV_LEFT] = 1'b1;
          end else begin
            ev_set[`CPW_EV_RIGHT] = 1'b1;
          end
        end
      end
    end

    if (pos_mode && s.run && s.actual == s.target) begin
      next_s.run = 1'b0;
      ev_set[`CPW_EV_TARGET] = 1'b1;
    end

    if (enc_step) begin
      next_s.enc = we.pos;
    end
    if (capture_strobe) begin
      next_s.latch = s.actual;
    end

    // Software writes take precedence over motion in the same cycle
    if (dphase_wr) begin
      case (s.idx)
        `CPW_IDX_GEN_CONF: next_s.gen = hwdata;
        `CPW_IDX_REF_CONF: next_s.refc = hwdata;
        `CPW_IDX_RAMP_KIND: next_s.ramp = hwdata[2:0];
        `CPW_IDX_ACTUAL: next_s.actual = hwdata;
        `CPW_IDX_TARGET: begin
          next_s.target = hwdata;
          next_s.run = 1'b1;
        end
        `CPW_IDX_LEFT: next_s.left = hwdata;
        `CPW_IDX_RIGHT: next_s.right = hwdata;
        `CPW_IDX_LATCH_REV: next_s.range = hwdata;
        `CPW_IDX_ENC_POS: next_s.enc = hwdata;
        `CPW_IDX_INT_CLEAR: next_s.ist = s.ist & ~hwdata[3:0];
        `CPW_IDX_INT_ENABLE: next_s.ien = hwdata[3:0];
        `CPW_IDX_EXTENSION: next_s.ext = hwdata;
        default: next_s.gen = next_s.gen;
      endcase
    end

    if (!s.refc[`CPW_REF_CIRC]) begin
      next_s.rev = `CPW_RST_WORD;
      next_s.acc = `CPW_RST_WORD;
      next_s.hold = 2'h0;
    end

    // New events win over a read-clear or write-clear in the same cycle
    next_s.events = next_s.events | ev_set;
    next_s.ist = next_s.ist | ev_set;
    next_s.irq = |(next_s.ist & next_s.ien);
    next_s.vstop_o = |next_s.events[1:0];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.ready <= `CPW_RST_READY;
    end else begin
      s <= next_s;
    end
  end

  assign hrdata = s.rdata;
  assign hreadyout = s.ready;
  assign hresp = 1'b0;
  assign step_out = s.step_o;
  assign move_dir = s.dir_o;
  assign vstop_ramp = s.vstop_o;
  assign actual_position = s.actual;
  assign irq = s.irq;

  a_wrap_forward: assert property (@(posedge hclk) disable iff (!hresetn)
    (step_ok && s.hold == 2'h0 && dir_use && circ_act && !dphase_wr &&
     s.actual == s.range - 32'h00000001)
    |=> s.actual == 32'h00000000 - $past(s.range))
    else $error("forward wrap did not land on minus range");

  a_rev_count_up: assert property (@(posedge hclk) disable iff (!hresetn)
    (step_ok && s.hold == 2'h0 && w.fwd && s.refc[`CPW_REF_CIRC])
    |=> s.rev == $past(s.rev) + 32'h00000001)
    else $error("revolution counter did not count up on wrap");

  a_hold_step: assert property (@(posedge hclk) disable iff (!hresetn)
    (step_ok && s.hold != 2'h0 && !dphase_wr)
    |=> s.actual == $past(s.actual) && s.step_o)
    else $error("held step moved the position");

  a_rev_cleared: assert property (@(posedge hclk) disable iff (!hresetn)
    !s.refc[`CPW_REF_CIRC] |=> s.rev == 32'h00000000)
    else $error("revolution counter not zero with circular off");

  a_shared_rev: assert property (@(posedge hclk) disable iff (!hresetn)
    (dphase_rd && s.idx == `CPW_IDX_LATCH_REV && s.gen[`CPW_GEN_CNT_SEL])
    |=> s.rdata == $past(s.rev))
    else $error("shared address did not return revolution counter");

  a_shared_latch: assert property (@(posedge hclk) disable iff (!hresetn)
    (dphase_rd && s.idx == `CPW_IDX_LATCH_REV && !s.gen[`CPW_GEN_CNT_SEL])
    |=> s.rdata == $past(s.latch))
    else $error("shared address did not return captured position");

  a_event_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    (dphase_rd && s.idx == `CPW_IDX_EVENTS && ev_set[1:0] == 2'h0)
    |=> s.events[1:0] == 2'h0 && !s.vstop_o)
    else $error("event read did not clear stop events");

  a_stop_request: assert property (@(posedge hclk) disable iff (!hresetn)
    (ev_set[1:0] != 2'h0) |=> s.vstop_o ##1 !s.step_o)
    else $error("zone limit did not raise stop and freeze steps");

  a_bus_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    take |=> !hreadyout ##1 hreadyout)
    else $error("slave wait state not exactly one cycle");

endmodule
`default_nettype wire

/* File: rtl/cpw_params.svh */
/*
  Register indices, field positions and reset values of the circular
  position wrap block. Assumes word-aligned AHB-Lite access: byte
  address = index * 4.
*/
`ifndef CPW_PARAMS_SVH
`define CPW_PARAMS_SVH

`define CPW_IDX_GEN_CONF 8'h00
`define CPW_IDX_REF_CONF 8'h01
`define CPW_IDX_EVENTS 8'h0E
`define CPW_IDX_RAMP_KIND 8'h20
`define CPW_IDX_ACTUAL 8'h21
`define CPW_IDX_TARGET 8'h37
`define CPW_IDX_LEFT 8'h33
`define CPW_IDX_RIGHT 8'h34
`define CPW_IDX_LATCH_REV 8'h36
`define CPW_IDX_ENC_POS 8'h50
`define CPW_IDX_INT_STATUS 8'h70
`define CPW_IDX_INT_CLEAR 8'h71
`define CPW_IDX_INT_ENABLE 8'h72
`define CPW_IDX_EXTENSION 8'h7C

`define CPW_GEN_CNT_SEL 0
`define CPW_REF_LEFT_EN 0
`define CPW_REF_RIGHT_EN 1
`define CPW_REF_CIRC 2
`define CPW_REF_ENC_CIRC 3
`define CPW_RAMP_POS 2

`define CPW_EV_LEFT 0
`define CPW_EV_RIGHT 1
`define CPW_EV_TARGET 2
`define CPW_EV_WRAP 3

`define CPW_RST_WORD 32'h00000000
`define CPW_RST_READY 1'b1

`endif

/* File: rtl/cpw_pkg.sv */
/*
  Types of the circular position wrap block: bus phase, wrap result and
  the whole register state. Assumes nothing of its surroundings.
*/
package cpw_pkg;

  typedef enum logic [1:0] {
    CPW_BUS_IDLE = 2'b00,
    CPW_BUS_DATA = 2'b01
  } cpw_bus_e;

  typedef struct packed {
    logic [31:0] pos;
    logic fwd;
    logic back;
  } cpw_wrap_s;

  typedef struct packed {
    cpw_bus_e bus;
    logic [7:0] idx;
    logic wr;
    logic [31:0] rdata;
    logic ready;
    logic [31:0] gen;
    logic [31:0] refc;
    logic [2:0] ramp;
    logic [31:0] left;
    logic [31:0] right;
    logic [31:0] range;
    logic [31:0] ext;
    logic [31:0] actual;
    logic [31:0] target;
    logic [31:0] enc;
    logic [31:0] latch;
    logic [31:0] rev;
    logic [31:0] acc;
    logic [1:0] hold;
    logic run;
    logic [3:0] events;
    logic [3:0] ist;
    logic [3:0] ien;
    logic irq;
    logic step_o;
    logic dir_o;
    logic vstop_o;
  } cpw_state_s;

endpackage

/* File: verif/cpw_top_tb.sv */
/*
  Self-checking bench of cpw_top: AHB-Lite register tasks and one task per scenario.
  Assumes the register indices and field positions of cpw_params.svh.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cpw_params.svh"

module cpw_top_tb
  import cpw_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic step_req = 1'b0;
  logic step_req_dir = 1'b0;
  logic enc_step = 1'b0;
  logic enc_dir = 1'b0;
  logic capture_strobe = 1'b0;
  logic [31:0] hrdata;
  logic [31:0] actual_position;
  logic hreadyout;
  logic hresp;
  logic step_out;
  logic move_dir;
  logic vstop_ramp;
  logic irq;
  logic [31:0] v;
  int errors = 0;
  int checks = 0;
  int cyc = 0;
  int pulses = 0;

  cpw_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .step_req(step_req), .step_req_dir(step_req_dir),
    .enc_step(enc_step), .enc_dir(enc_dir), .capture_strobe(capture_strobe),
    .step_out(step_out), .move_dir(move_dir), .vstop_ramp(vstop_ramp),
    .actual_position(actual_position), .irq(irq));

  initial begin
    forever #5 hclk = ~hclk;
  end

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // A hung handshake must still reach the verdict
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      end_of_test();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'h0};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, idx, d, x);
  endtask

  task automatic rd(input logic [7:0] idx);
    bus(1'b0, idx, 32'h0, v);
  endtask

  // Registered flags land one edge late; sample clear of the edge
  task automatic settle();
    repeat (2) @(posedge hclk);
    #1;
  endtask

  // Counts step_out pulses, looked at once the launching edge has settled
  task automatic step(input logic d, input int n);
    pulses = 0;
    repeat (n) begin
      @(posedge hclk);
      step_req <= 1'b1;
      step_req_dir <= d;
      @(posedge hclk);
      step_req <= 1'b0;
      #1;
      if (step_out === 1'b1) begin
        pulses++;
      end
      @(posedge hclk);
    end
  endtask

  task automatic t_reset();
    rd(`CPW_IDX_GEN_CONF);
    chk("gen_conf", v, 32'h0);
    rd(8'h05);
    chk("unmapped", v, 32'h0);
    chk("hresp", {31'h0, hresp}, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_wrap();
    wr(`CPW_IDX_LATCH_REV, 32'h4);
    wr(`CPW_IDX_REF_CONF, 32'h4);
    wr(`CPW_IDX_RAMP_KIND, 32'h0);
    wr(`CPW_IDX_ACTUAL, 32'h3);
    wr(`CPW_IDX_INT_ENABLE, 32'h8);
    @(posedge hclk);
    capture_strobe <= 1'b1;
    @(posedge hclk);
    capture_strobe <= 1'b0;
    step(1'b1, 1);
    chk("pos_fwd", actual_position, 32'hFFFFFFFC);
    settle();
    chk("irq_set", {31'h0, irq}, 32'h1);
    rd(`CPW_IDX_LATCH_REV);
    chk("latch", v, 32'h3);
    wr(`CPW_IDX_GEN_CONF, 32'h1);
    rd(`CPW_IDX_LATCH_REV);
    chk("rev_up", v, 32'h1);
    wr(`CPW_IDX_INT_CLEAR, 32'h8);
    wr(`CPW_IDX_INT_ENABLE, 32'h0);
    step(1'b0, 1);
    chk("pos_back", actual_position, 32'h3);
    settle();
    chk("irq_mask", {31'h0, irq}, 32'h0);
    rd(`CPW_IDX_LATCH_REV);
    chk("rev_down", v, 32'h0);
    step(1'b1, 1);
    wr(`CPW_IDX_REF_CONF, 32'h0);
    rd(`CPW_IDX_LATCH_REV);
    chk("rev_off", v, 32'h0);
    $display("test wrap done");
  endtask

  // Range 2 gives four positions per turn; each held step eats one request
  task automatic t_ext(input logic [31:0] ext, input int n, input logic [31:0] exp);
    wr(`CPW_IDX_REF_CONF, 32'h0);
    wr(`CPW_IDX_LATCH_REV, 32'h2);
    wr(`CPW_IDX_EXTENSION, ext);
    wr(`CPW_IDX_ACTUAL, 32'h1);
    wr(`CPW_IDX_REF_CONF, 32'h4);
    step(1'b1, n);
    chk("ext_pos", actual_position, exp);
    chk("ext_pulses", pulses, n);
    $display("test extension %h done", ext);
  endtask

  task automatic t_path();
    wr(`CPW_IDX_REF_CONF, 32'h4);
    wr(`CPW_IDX_LATCH_REV, 32'h12C);
    wr(`CPW_IDX_RAMP_KIND, 32'h4);
    wr(`CPW_IDX_ACTUAL, 32'hC8);
    wr(`CPW_IDX_TARGET, 32'hFFFFFF38);
    step(1'b0, 1);
    chk("short_dir", {31'h0, move_dir}, 32'h1);
    chk("short_pos", actual_position, 32'hC9);
    wr(`CPW_IDX_LEFT, 32'hFFFFFF06);
    wr(`CPW_IDX_RIGHT, 32'hFA);
    wr(`CPW_IDX_REF_CONF, 32'h7);
    wr(`CPW_IDX_ACTUAL, 32'hC8);
    wr(`CPW_IDX_TARGET, 32'hFFFFFF38);
    step(1'b1, 1);
    chk("zone_dir", {31'h0, move_dir}, 32'h0);
    chk("zone_pos", actual_position, 32'hC7);
    $display("test path done");
  endtask

  task automatic t_zone();
    wr(`CPW_IDX_RAMP_KIND, 32'h0);
    wr(`CPW_IDX_LEFT, 32'hA);
    wr(`CPW_IDX_RIGHT, 32'hFFFFFFF6);
    wr(`CPW_IDX_ACTUAL, 32'hC);
    step(1'b0, 2);
    settle();
    chk("vstop_on", {31'h0, vstop_ramp}, 32'h1);
    step(1'b0, 1);
    chk("frozen", actual_position, 32'hA);
    chk("frozen_pulse", pulses, 32'h0);
    rd(`CPW_IDX_EVENTS);
    chk("stop_ev", 32'(|v[1:0]), 32'h1);
    settle();
    chk("vstop_off", {31'h0, vstop_ramp}, 32'h0);
    rd(`CPW_IDX_EVENTS);
    chk("ev_clr", {30'h0, v[1:0]}, 32'h0);
    wr(`CPW_IDX_RAMP_KIND, 32'h4);
    wr(`CPW_IDX_TARGET, 32'h14);
    step(1'b0, 1);
    chk("leave_pos", actual_position, 32'hB);
    chk("leave_dir", {31'h0, move_dir}, 32'h1);
    $display("test zone done");
  endtask

  task automatic t_enc();
    wr(`CPW_IDX_REF_CONF, 32'hC);
    wr(`CPW_IDX_LATCH_REV, 32'h4);
    wr(`CPW_IDX_ENC_POS, 32'h3);
    @(posedge hclk);
    enc_step <= 1'b1;
    enc_dir <= 1'b1;
    @(posedge hclk);
    enc_step <= 1'b0;
    rd(`CPW_IDX_ENC_POS);
    chk("enc_wrap", v, 32'hFFFFFFFC);
    $display("test encoder done");
  endtask

  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_wrap();
    t_ext(32'h40000000, 9, 32'h1);
    t_ext(32'h80000000, 8, 32'hFFFFFFFF);
    t_ext(32'hC0000000, 9, 32'hFFFFFFFF);
    t_path();
    t_zone();
    t_enc();
    end_of_test();
  end
endmodule

`default_nettype wire
